// ### src/qip_alu.sv
// eight bit arithmetic and logic unit of the pipeline core
`timescale 1ns/100ps
module qip_alu
(
   input qip_pkg::qip_alu_e op_i,
   input logic [7:0] a_i,
   input logic [7:0] b_i,
   input logic [2:0] bit_i,
   input logic c_i,
   output logic [7:0] res_o,
   output logic c_o,
   output logic dc_o,
   output logic z_o
);
   import qip_pkg::*;

   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] mask;

   always_comb
   begin
      mask = 8'h01 << bit_i;
      sum = 9'h000;
      nib = 5'h00;
      res_o = b_i;
      c_o = c_i;
      dc_o = 1'b0;
      case (op_i)
         ALU_PASS_A: res_o = a_i;
         ALU_PASS_B: res_o = b_i;
         ALU_CLR: res_o = 8'h00;
         ALU_ADD:
         begin
            sum = {1'b0, b_i} + {1'b0, a_i};
            nib = {1'b0, b_i[3:0]} + {1'b0, a_i[3:0]};
            res_o = sum[7:0];
            c_o = sum[8];
            dc_o = nib[4];
         end
         ALU_SUB:
         begin
            // two's complement: carry out high means no borrow
            sum = {1'b0, b_i} + {1'b0, ~a_i} + 9'h001;
            nib = {1'b0, b_i[3:0]} + {1'b0, ~a_i[3:0]} + 5'h01;
            res_o = sum[7:0];
            c_o = sum[8];
            dc_o = nib[4];
         end
         ALU_AND: res_o = a_i & b_i;
         ALU_IOR: res_o = a_i | b_i;
         ALU_XOR: res_o = a_i ^ b_i;
         ALU_COM: res_o = ~b_i;
         ALU_INC: res_o = b_i + 8'h01;
         ALU_DEC: res_o = b_i - 8'h01;
         ALU_RLF:
         begin
            res_o = {b_i[6:0], c_i};
            c_o = b_i[7];
         end
         ALU_RRF:
         begin
            res_o = {c_i, b_i[7:1]};
            c_o = b_i[0];
         end
         ALU_SWAP: res_o = {b_i[3:0], b_i[7:4]};
         ALU_BCLR: res_o = b_i & ~mask;
         ALU_BSET: res_o = b_i | mask;
         default: res_o = b_i;
      endcase
      z_o = (res_o == 8'h00);
   end

endmodule : qip_alu

// ### src/qip_core.sv
// quad phase fetch and execute pipeline core with working accumulator
`timescale 1ns/100ps
module qip_core
#(
   parameter int PM_WORDS = qip_pkg::PM_WORDS_DEF,
   parameter int STK_DEPTH = qip_pkg::STK_DEPTH_DEF,
   parameter int PC_W = $clog2(PM_WORDS),
   parameter int SP_W = $clog2(STK_DEPTH)
)
(
   // clk_i is the clock arriving on the oscillator pin
   input wire logic clk_i,
   input wire logic rst_i,
   output logic [PC_W-1:0] pm_addr_o,
   input wire logic [qip_pkg::IW-1:0] pm_data_i,
   output logic [qip_pkg::FA_W-1:0] df_addr_o,
   output logic df_rd_o,
   input wire logic [qip_pkg::DW-1:0] df_rdata_i,
   output logic df_wr_o,
   output logic [qip_pkg::DW-1:0] df_wdata_o,
   output logic [3:0] phase_o,
   output logic [qip_pkg::DW-1:0] w_o,
   output logic [qip_pkg::DW-1:0] status_o
);
   import qip_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      qip_phase_e phase;
      logic [3:0] phase_oh;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] pm_addr;
      logic [IW-1:0] opcode_latch;
      logic [IW-1:0] exec_word;
      logic flush;
      logic [7:0] w;
      logic [7:0] status;
      logic [7:0] fsr;
      logic [4:0] pclath;
      logic [7:0] operand;
      logic [7:0] result;
      logic res_c;
      logic res_dc;
      logic res_z;
      logic [SP_W-1:0] sp;
      logic [STK_DEPTH-1:0][PC_W-1:0] stack;
      logic [FA_W-1:0] df_addr;
      logic df_rd;
      logic df_wr;
      logic [7:0] df_wdata;
   } qip_core_s;

   localparam qip_core_s CORE_RST = '{
      phase: PH_ONE,
      phase_oh: RST_PHASE_OH,
      status: RST_STATUS,
      opcode_latch: NOP_WORD,
      exec_word: NOP_WORD,
      default: '0};

   qip_core_s s;
   qip_core_s next_s;

   ////////////////////////////////////////////////////////////////////////
   // decode

   logic [IW-1:0] ir;
   qip_alu_e alu_op;
   logic use_lit;
   logic dst_w;
   logic dst_f;
   logic fz;
   logic fc;
   logic fdc;
   logic skip_z;
   logic skip_bit;
   logic rd_f;
   logic jump;
   logic push;
   logic pop;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_z;
   logic [FA_W-1:0] f_addr;
   logic [7:0] rd_val;
   logic [12:0] goto_tgt;
   logic [12:0] pcl_tgt;

   // held inside the core rather than in the external file
   function automatic logic core_reg(input logic [6:0] a);
      core_reg = (a == ADR_INDIRECT) || (a == ADR_PCL) ||
         (a == ADR_STATUS) || (a == ADR_FSR) || (a == ADR_PCLATH);
   endfunction : core_reg

   // in phase one the incoming word is decoded so the read can be set up
   always_comb
   begin
      if (s.phase == PH_ONE)
      begin
         ir = s.flush ? NOP_WORD : s.opcode_latch;
      end
      else
      begin
         ir = s.exec_word;
      end
   end

   always_comb
   begin
      alu_op = ALU_PASS_A;
      use_lit = 1'b0;
      dst_w = 1'b0;
      dst_f = 1'b0;
      fz = 1'b0;
      fc = 1'b0;
      fdc = 1'b0;
      skip_z = 1'b0;
      skip_bit = 1'b0;
      rd_f = 1'b0;
      jump = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      case (ir[13:12])
         2'b00:
         begin
            alu_op = BYTE_OP[ir[11:8]];
            dst_w = !ir[7] && (ir[11:8] != 4'h0);
            dst_f = ir[7];
            fz = BYTE_FZ[ir[11:8]];
            fc = BYTE_FC[ir[11:8]];
            fdc = BYTE_FDC[ir[11:8]];
            skip_z = BYTE_SKIPZ[ir[11:8]];
            rd_f = BYTE_RD[ir[11:8]];
            pop = (ir[11:1] == 11'h004);
         end
         2'b01:
         begin
            alu_op = ir[10] ? ALU_BSET : ALU_BCLR;
            rd_f = 1'b1;
            dst_f = !ir[11];
            skip_bit = ir[11];
         end
         2'b10:
         begin
            jump = 1'b1;
            push = !ir[11];
         end
         default:
         begin
            alu_op = LIT_OP[ir[11:8]];
            use_lit = 1'b1;
            dst_w = (ir[11:8] != 4'hb);
            fz = LIT_FZ[ir[11:8]];
            fc = LIT_FC[ir[11:8]];
            fdc = LIT_FC[ir[11:8]];
            pop = (ir[11:10] == 2'b01);
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // operand path

   // bank select or the indirect pointer extends the seven bit field
   always_comb
   begin
      if (ir[6:0] == ADR_INDIRECT)
      begin
         f_addr = {s.status[ST_IRP], s.fsr};
      end
      else
      begin
         f_addr = {s.status[ST_RP1], s.status[ST_RP0], ir[6:0]};
      end
   end

   always_comb
   begin
      case (s.df_addr[6:0])
         ADR_INDIRECT: rd_val = 8'h00;
         ADR_PCL: rd_val = s.pm_addr[7:0];
         ADR_STATUS: rd_val = s.status;
         ADR_FSR: rd_val = s.fsr;
         ADR_PCLATH: rd_val = {3'b000, s.pclath};
         default: rd_val = df_rdata_i;
      endcase
   end

   assign alu_b = use_lit ? ir[7:0] : s.operand;

   qip_alu u_alu
   (
      .op_i(alu_op),
      .a_i(s.w),
      .b_i(alu_b),
      .bit_i(ir[9:7]),
      .c_i(s.status[ST_C]),
      .res_o(alu_res),
      .c_o(alu_c),
      .dc_o(alu_dc),
      .z_o(alu_z)
   );

   assign goto_tgt = {s.pclath[4:3], s.exec_word[10:0]};
   assign pcl_tgt = {s.pclath, s.result};

   ////////////////////////////////////////////////////////////////////////
   // phase sequencing

   always_comb
   begin
      next_s = s;
      // the phase ring never stalls; one turn is one instruction cycle
      next_s.phase = qip_phase_e'(s.phase + 2'b01);
      next_s.phase_oh = {s.phase_oh[2:0], s.phase_oh[3]};
      case (s.phase)
         PH_ONE:
         begin
            next_s.pm_addr = s.pc;
            next_s.pc = s.pc + 1'b1;
            next_s.exec_word = ir;
            // a dropped word has already been swapped for the no-op above
            next_s.flush = 1'b0;
            next_s.df_addr = f_addr;
            next_s.df_rd = rd_f && !core_reg(f_addr[6:0]);
         end
         PH_TWO:
         begin
            next_s.df_rd = 1'b0;
            next_s.operand = rd_val;
         end
         PH_THREE:
         begin
            next_s.result = alu_res;
            next_s.res_c = alu_c;
            next_s.res_dc = alu_dc;
            next_s.res_z = alu_z;
            next_s.df_wr = dst_f && !core_reg(s.df_addr[6:0]);
            next_s.df_wdata = alu_res;
         end
         PH_FOUR:
         begin
            // the next word lands while this one commits; the whole
            // fourteen bit word arrives in one fetch, no second beat
            next_s.opcode_latch = pm_data_i;
            next_s.df_wr = 1'b0;
            if (dst_w)
            begin
               next_s.w = s.result;
            end
            if (dst_f)
            begin
               case (s.df_addr[6:0])
                  ADR_PCL:
                  begin
                     next_s.pc = PC_W'(pcl_tgt);
                     next_s.flush = 1'b1;
                  end
                  ADR_STATUS:
                  begin
                     // time-out and power-down bits are not writable
                     next_s.status = {s.result[7:5], s.status[4:3],
                        s.result[2:0]};
                  end
                  ADR_FSR: next_s.fsr = s.result;
                  ADR_PCLATH: next_s.pclath = s.result[4:0];
                  default: next_s.status = s.status;
               endcase
            end
            // flag updates win over a direct write to the status byte
            if (fz)
            begin
               next_s.status[ST_Z] = s.res_z;
            end
            if (fc)
            begin
               next_s.status[ST_C] = s.res_c;
            end
            if (fdc)
            begin
               next_s.status[ST_DC] = s.res_dc;
            end
            // a skip keeps the counter running and only drops the word
            if ((skip_z && s.res_z) ||
               (skip_bit && (s.operand[ir[9:7]] == ir[10])))
            begin
               next_s.flush = 1'b1;
            end
            // upper target bits come from the latch, not the opcode
            if (jump)
            begin
               next_s.pc = PC_W'(goto_tgt);
               next_s.flush = 1'b1;
            end
            // stack is circular; overflow silently wraps
            if (push)
            begin
               next_s.stack[s.sp] = s.pm_addr;
               next_s.sp = s.sp + 1'b1;
            end
            if (pop)
            begin
               next_s.sp = s.sp - 1'b1;
               next_s.pc = s.stack[SP_W'(s.sp - 1'b1)];
               next_s.flush = 1'b1;
            end
         end
         default:
         begin
            next_s.phase = PH_ONE;
         end
      endcase
   end

   // one word fetched per turn while the previous executes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= CORE_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign pm_addr_o = s.pm_addr;
   assign df_addr_o = s.df_addr;
   assign df_rd_o = s.df_rd;
   assign df_wr_o = s.df_wr;
   assign df_wdata_o = s.df_wdata;
   assign phase_o = s.phase_oh;
   assign w_o = s.w;
   assign status_o = s.status;

endmodule : qip_core

// ### src/qip_pkg.sv
// shared constants and types of the quad phase instruction pipeline core
// Notes on behaviour
// - oscillator clock divided into four phases
// - program counter steps in phase one
// - fetched word captured in phase four
// - execute latches at one, runs two-four
// - data read phase two, write phase four
// - fetch overlaps execute, one per cycle
// - program counter change costs two cycles
// - single fourteen bit instruction word fetch
// - program space one to eight K
// - program and data on separate buses
// - special registers mapped, direct and indirect
// - eight bit add, subtract, shift, logic
// - accumulator against file or literal operand
// - accumulator is unaddressed eight bit register
// - carry, nibble and zero flags updated
// - subtraction flags mean no borrow
package qip_pkg;

   localparam int IW = 14;
   localparam int DW = 8;
   localparam int FA_W = 9;
   localparam int PM_WORDS_DEF = 8192;
   localparam int STK_DEPTH_DEF = 8;

   localparam logic [IW-1:0] NOP_WORD = 14'h0000;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [3:0] RST_PHASE_OH = 4'h1;

   // core held registers, mirrored in every bank
   localparam logic [6:0] ADR_INDIRECT = 7'h00;
   localparam logic [6:0] ADR_PCL = 7'h02;
   localparam logic [6:0] ADR_STATUS = 7'h03;
   localparam logic [6:0] ADR_FSR = 7'h04;
   localparam logic [6:0] ADR_PCLATH = 7'h0a;

   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_RP0 = 5;
   localparam int ST_RP1 = 6;
   localparam int ST_IRP = 7;

   typedef enum logic [1:0] {
      PH_ONE = 2'b00,
      PH_TWO = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR = 2'b11
   } qip_phase_e;

   typedef enum logic [3:0] {
      ALU_PASS_A = 4'b0000,
      ALU_PASS_B = 4'b0001,
      ALU_CLR = 4'b0010,
      ALU_ADD = 4'b0011,
      ALU_SUB = 4'b0100,
      ALU_AND = 4'b0101,
      ALU_IOR = 4'b0110,
      ALU_XOR = 4'b0111,
      ALU_COM = 4'b1000,
      ALU_INC = 4'b1001,
      ALU_DEC = 4'b1010,
      ALU_RLF = 4'b1011,
      ALU_RRF = 4'b1100,
      ALU_SWAP = 4'b1101,
      ALU_BCLR = 4'b1110,
      ALU_BSET = 4'b1111
   } qip_alu_e;

   // byte oriented group, indexed by opcode bits 11:8
   localparam qip_alu_e BYTE_OP [16] = '{
      ALU_PASS_A, ALU_CLR, ALU_SUB, ALU_DEC, ALU_IOR, ALU_AND,
      ALU_XOR, ALU_ADD, ALU_PASS_B, ALU_COM, ALU_INC, ALU_DEC,
      ALU_RRF, ALU_RLF, ALU_SWAP, ALU_INC};
   localparam logic [15:0] BYTE_FZ = 16'h07fe;
   localparam logic [15:0] BYTE_FC = 16'h3084;
   localparam logic [15:0] BYTE_FDC = 16'h0084;
   localparam logic [15:0] BYTE_SKIPZ = 16'h8800;
   localparam logic [15:0] BYTE_RD = 16'hfffc;

   // literal group, indexed by opcode bits 11:8
   localparam qip_alu_e LIT_OP [16] = '{
      ALU_PASS_B, ALU_PASS_B, ALU_PASS_B, ALU_PASS_B,
      ALU_PASS_B, ALU_PASS_B, ALU_PASS_B, ALU_PASS_B,
      ALU_IOR, ALU_AND, ALU_XOR, ALU_PASS_A,
      ALU_SUB, ALU_SUB, ALU_ADD, ALU_ADD};
   localparam logic [15:0] LIT_FZ = 16'hf700;
   localparam logic [15:0] LIT_FC = 16'hf000;

endpackage : qip_pkg

// ### verif/qip_core_properties.sv
// port assertions for the quad phase pipeline core
`timescale 1ns/100ps
module qip_core_properties
#(
   parameter int PC_W = 10
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [PC_W-1:0] pm_addr_o,
   input wire logic [qip_pkg::IW-1:0] pm_data_i,
   input wire logic [qip_pkg::FA_W-1:0] df_addr_o,
   input wire logic df_rd_o,
   input wire logic [qip_pkg::DW-1:0] df_rdata_i,
   input wire logic df_wr_o,
   input wire logic [qip_pkg::DW-1:0] df_wdata_o,
   input wire logic [3:0] phase_o,
   input wire logic [qip_pkg::DW-1:0] w_o,
   input wire logic [qip_pkg::DW-1:0] status_o
);
   import qip_pkg::*;
   logic [3:0] rot;
   assign rot = {phase_o[2:0], phase_o[3]};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   sequence rd_then_wr;
      df_rd_o ##2 df_wr_o;
   endsequence
   sequence jump_fetched;
      phase_o == 4'b1000 && pm_data_i[13:11] == 3'b101;
   endsequence
   // the cycle after a taken jump runs a no-op: no strobe, no state change
   sequence flush_quiet;
      (!df_rd_o && !df_wr_o) [*4] ##1 ($stable(w_o) && $stable(status_o));
   endsequence
   // sampled reset keeps the release edge out of the rotation check
   phase_turn_a: assert property (!rst_i |=> phase_o == $past(rot))
      else $error("phase did not rotate");
   phase_hot_a: assert property ($onehot(phase_o))
      else $error("phase not one-hot");
   fetch_edge_a: assert property ($changed(pm_addr_o) |-> phase_o == 4'b0010)
      else $error("fetch address moved outside phase one");
   fetch_hold_a: assert property (phase_o == 4'b0010 |=> $stable(pm_addr_o) [*3])
      else $error("fetch address not held");
   rd_phase_a: assert property (df_rd_o |-> phase_o == 4'b0010)
      else $error("read strobe outside phase two");
   wr_phase_a: assert property (df_wr_o |-> phase_o == 4'b1000)
      else $error("write strobe outside phase four");
   rd_single_a: assert property (df_rd_o |=> !df_rd_o [*3])
      else $error("second read in one cycle");
   rmw_addr_a: assert property (rd_then_wr |-> df_addr_o == $past(df_addr_o, 2))
      else $error("write address differs from read address");
   daddr_edge_a: assert property ($changed(df_addr_o) |-> phase_o == 4'b0010)
      else $error("data address moved outside phase one");
   acc_edge_a: assert property ($changed(w_o) |-> phase_o == 4'b0001)
      else $error("accumulator changed mid cycle");
   flag_edge_a: assert property ($changed(status_o) |-> phase_o == 4'b0001 && status_o[4:3] == 2'b11)
      else $error("status changed mid cycle or fixed bits lost");
   jump_quiet_a: assert property (jump_fetched |-> ##5 flush_quiet)
      else $error("flushed word touched the core state");
endmodule : qip_core_properties

bind qip_core qip_core_properties #(.PC_W(PC_W)) u_qip_core_properties (
   .clk_i(clk_i), .rst_i(rst_i), .pm_addr_o(pm_addr_o),
   .pm_data_i(pm_data_i), .df_addr_o(df_addr_o), .df_rd_o(df_rd_o),
   .df_rdata_i(df_rdata_i), .df_wr_o(df_wr_o), .df_wdata_o(df_wdata_o),
   .phase_o(phase_o), .w_o(w_o), .status_o(status_o));

// ### verif/qip_mem_model.sv
// behavioural program memory and data file facing the core
`timescale 1ns/100ps
module qip_mem_model
#(
   parameter int PC_W = 10
)
(
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic [3:0] phase_i,
   input wire logic [PC_W-1:0] pm_addr_i,
   output logic [qip_pkg::IW-1:0] pm_data_o,
   input wire logic [qip_pkg::FA_W-1:0] df_addr_i,
   input wire logic df_rd_i,
   output logic [qip_pkg::DW-1:0] df_rdata_o,
   input wire logic df_wr_i,
   input wire logic [qip_pkg::DW-1:0] df_wdata_i
);
   import qip_pkg::*;
   logic [IW-1:0] prog [2**PC_W];
   logic [DW-1:0] ram [512];
   logic [DW-1:0] junk = 8'h5a;
   // slow mode shows a wrong word until the capturing phase
   assign pm_data_o = (slow_i && !phase_i[3]) ? ~prog[pm_addr_i]
      : prog[pm_addr_i];
   // unselected read bus carries a moving pattern, never the last value
   assign df_rdata_o = df_rd_i ? ram[df_addr_i] : junk;
   always @(posedge clk_i)
   begin
      junk <= junk + 8'h3b;
      if (df_wr_i)
      begin
         ram[df_addr_i] <= df_wdata_i;
      end
   end
endmodule : qip_mem_model

// ### verif/test_quad_phase_instruction_pipeline.sv
// self-checking bench for the quad phase pipeline core
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("unexpected at %0t: got %h expected %h", $time, g, e); \
      end \
   end
module test_quad_phase_instruction_pipeline;
   import qip_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic slow = 1'b0;
   logic [9:0] pm_addr;
   logic [IW-1:0] pm_data;
   logic [FA_W-1:0] df_addr;
   logic df_rd;
   logic df_wr;
   logic [DW-1:0] df_rdata;
   logic [DW-1:0] df_wdata;
   logic [DW-1:0] w;
   logic [DW-1:0] status;
   logic [3:0] phase;
   logic [16:0] exp_q [$];
   logic [16:0] exp_v;
   logic [5:0] ops [5] = '{6'h3e, 6'h3c, 6'h39, 6'h38, 6'h3a};
   int seed = 97306;
   int n_errors = 0;
   int total_checks = 0;
   int pc;
   qip_core #(.PM_WORDS(1024)) u_qip_core (.clk_i(clk_i), .rst_i(rst_i),
      .pm_addr_o(pm_addr), .pm_data_i(pm_data), .df_addr_o(df_addr),
      .df_rd_o(df_rd), .df_rdata_i(df_rdata), .df_wr_o(df_wr),
      .df_wdata_o(df_wdata), .phase_o(phase), .w_o(w), .status_o(status));
   qip_mem_model #(.PC_W(10)) u_qip_mem_model (.clk_i(clk_i), .slow_i(slow),
      .phase_i(phase), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
      .df_addr_i(df_addr), .df_rd_i(df_rd), .df_rdata_o(df_rdata),
      .df_wr_i(df_wr), .df_wdata_i(df_wdata));
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task put(input logic [13:0] word);
      u_qip_mem_model.prog[pc] = word;
      pc++;
   endtask : put
   // random literal ops, flags tracked as software would see them
   task automatic build();
      int tmp;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] r;
      logic [4:0] lo;
      logic c;
      logic dc;
      pc = 0;
      c = 1'b0;
      dc = 1'b0;
      exp_q.delete();
      for (int j = 0; j < 1024; j++)
         u_qip_mem_model.prog[j] = NOP_WORD;
      for (int i = 0; i < 20; i++)
      begin
         tmp = $random(seed);
         a = tmp[7:0];
         b = tmp[15:8];
         lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
         case (i % 5)
            0: {c, r} = {1'b0, a} + {1'b0, b};
            1: {c, r} = {b >= a, b - a};
            2: r = a & b;
            3: r = a | b;
            default: r = a ^ b;
         endcase
         dc = (i % 5 == 0) ? lo[4] : (i % 5 == 1) ? b[3:0] >= a[3:0] : dc;
         put({6'h30, a});
         put({ops[i % 5], b});
         put(14'h00a0);
         exp_q.push_back({9'h020, r});
         put(14'h0803);
         put(14'h00a1);
         exp_q.push_back({9'h021, 5'b00011, r == 8'h00, dc, c});
         put(14'h08a0);
         exp_q.push_back({9'h020, r});
      end
      // indirect store, bit set, taken bit skip, call and literal return
      u_qip_mem_model.prog[10'h3f0] = 14'h3477;
      put(14'h3025);
      put(14'h0084);
      put(14'h303c);
      put(14'h0080);
      exp_q.push_back({9'h025, 8'h3c});
      put(14'h1425);
      exp_q.push_back({9'h025, 8'h3d});
      put(14'h1c25);
      // skipped store must never reach the file
      put(14'h00a6);
      put(14'h23f0);
      put(14'h00a7);
      exp_q.push_back({9'h027, 8'h77});
      tmp = pc + 2;
      put({3'b101, tmp[10:0]});
      // word behind the jump must vanish
      put(14'h00b0);
      put(14'h3055);
      put(14'h00a2);
      exp_q.push_back({9'h022, 8'h55});
      tmp = pc;
      put({3'b101, tmp[10:0]});
   endtask : build
   task conclude();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////
   always @(negedge clk_i)
   begin
      if (rst_i === 1'b0 && df_wr === 1'b1)
      begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 17'hx;
         `CHK(df_addr, exp_v[16:8])
         `CHK(df_wdata, exp_v[7:0])
      end
   end
   initial
   begin
      repeat (6000) @(posedge clk_i);
      n_errors++;
      $display("watchdog expired");
      conclude();
   end
   // second pass runs a slow memory; each pass starts from a fresh reset once the last program has finished
   initial
   begin
      for (int p = 0; p < 2; p++)
      begin
         rst_i <= 1'b1;
         @(posedge clk_i);
         build();
         slow <= p[0];
         repeat (20) @(posedge clk_i);
         rst_i <= 1'b0;
         for (int k = 0; k < 3000 && exp_q.size() > 0; k++)
            @(posedge clk_i);
         repeat (40) @(posedge clk_i);
         `CHK(exp_q.size(), 0)
         `CHK(w, 8'h55)
         $display("test pass %0d done", p);
      end
      conclude();
   end
endmodule : test_quad_phase_instruction_pipeline
